// ### psfs_pkg.sv
// shared constants and carriers of the power switch fault sequencer
// assumes a single 250 MHz clock and comparator levels already synchronous
package psfs_pkg;

	// clock rate, used to turn times into cycle counts
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned CNT_W           = 26;

	// nominal periods in microseconds
	localparam int unsigned BLANK_TIME_US   = 32000;
	localparam int unsigned RETRY_TIME_US   = 128000;
	localparam int unsigned SURGE_TIME_US   = 128000;
	localparam int unsigned LOCKOUT_TIME_US = 128000;

	// cycle counts derived from the periods
	localparam logic [CNT_W-1:0] BLANK_CYCLES   =
		CNT_W'(BLANK_TIME_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] RETRY_CYCLES   =
		CNT_W'(RETRY_TIME_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] SURGE_CYCLES   =
		CNT_W'(SURGE_TIME_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] LOCKOUT_CYCLES =
		CNT_W'(LOCKOUT_TIME_US * CLK_MHZ);

	localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0000000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 26'h0000001;

	// power path states, gray along disabled-arm-on-retry
	typedef enum logic [2:0] {
		PSFS_DISABLED = 3'h0,
		PSFS_ARM      = 3'h1,
		PSFS_ON       = 3'h3,
		PSFS_RETRY    = 3'h2,
		PSFS_BREAK    = 3'h6
	} psfs_power_t;

	// surge allowance states, gray along ready-surge-limit-lock
	typedef enum logic [1:0] {
		PSFS_READY = 2'h0,
		PSFS_SURGE = 2'h1,
		PSFS_LIMIT = 2'h3,
		PSFS_LOCK  = 2'h2
	} psfs_surge_t;

	// comparator and sensor levels, all active high
	typedef struct packed {
		logic input_below_trip;
		logic over_primary;
		logic secondary_overcurrent;
		logic over_temp;
	} psfs_sense_t;

	// drive levels toward the power stage
	typedef struct packed {
		logic pass_on;
		logic secondary_limit_sel;
		logic shunt_on;
	} psfs_drive_t;

	// observable state
	typedef struct packed {
		logic uv_disengaged;
		logic surge_active;
		logic primary_limiting;
		logic lockout_active;
		logic thermal_off;
	} psfs_status_t;

	localparam psfs_drive_t  DRIVE_RESET  = 3'h1;
	localparam psfs_status_t STATUS_RESET = 5'h00;

endpackage

// ### psfs_sequencer.sv
// power switch fault sequencer: undervoltage blanking and retry,
// surge allowance with lock-out, thermal override, discharge shunt
// assumes comparator levels are clean and synchronous to clock
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - load off after full blanking below trip
// R2 - wait retry period before reapplying power
// R3 - still low: powered one blanking, then repeat
// R4 - input above trip: normal conduction resumes
// R5 - undervoltage acts regardless of surge timer
// R6 - pass held off until monitor above threshold
// R7 - upward crossing restarts blanking timer
// R8 - secondary limit for surge period, then primary
// R9 - secondary overcurrent clamp acts immediately
// R10 - primary limiting held while overload persists
// R11 - lock-out after limiting ends, no surge
// R12 - over-temperature ends surge, output off
// R13 - after cooling primary limit, no surge
// R14 - disable: pass off before shunt on
// R15 - periods counted on internal clock cycles
// R16 - enable: shunt off before pass on
module psfs_sequencer #(
	parameter logic [psfs_pkg::CNT_W-1:0] BLANK_CYCLES   =
		psfs_pkg::BLANK_CYCLES,
	parameter logic [psfs_pkg::CNT_W-1:0] RETRY_CYCLES   =
		psfs_pkg::RETRY_CYCLES,
	parameter logic [psfs_pkg::CNT_W-1:0] SURGE_CYCLES   =
		psfs_pkg::SURGE_CYCLES,
	parameter logic [psfs_pkg::CNT_W-1:0] LOCKOUT_CYCLES =
		psfs_pkg::LOCKOUT_CYCLES
) (
	input  wire logic                   clock,
	input  wire logic                   nrst,
	input  wire logic                   enable,
	input  wire psfs_pkg::psfs_sense_t  sense,
	output psfs_pkg::psfs_drive_t       drive,
	output logic                        secondary_clamp,
	output psfs_pkg::psfs_status_t      status
);

	//////////////////////////////////////////////////////////////////////////
	// power path state

	psfs_pkg::psfs_power_t              power;
	psfs_pkg::psfs_power_t              next_power;
	logic [psfs_pkg::CNT_W-1:0]         power_cnt;
	logic [psfs_pkg::CNT_W-1:0]         next_power_cnt;
	// terminal flags keep the state machine readable
	logic                               blank_done;
	logic                               retry_done;

	// counts start at zero, so the last cycle is one short of the period
	assign blank_done = (power_cnt == BLANK_CYCLES - psfs_pkg::CNT_ONE);
	assign retry_done = (power_cnt == RETRY_CYCLES - psfs_pkg::CNT_ONE);

	// blanking and retry share one counter; only one runs at a time
	always_comb begin
		next_power = power;
		next_power_cnt = power_cnt;
		case (power)
			psfs_pkg::PSFS_DISABLED: begin
				next_power_cnt = psfs_pkg::CNT_ZERO;
				// R16 shunt released first
				if (enable) begin
					next_power = psfs_pkg::PSFS_ARM;
				end
			end

			psfs_pkg::PSFS_ARM: begin
				next_power_cnt = psfs_pkg::CNT_ZERO;
				if (!enable) begin
					next_power = psfs_pkg::PSFS_BREAK;
				// R6 wait for monitor above threshold
				end else if (!sense.input_below_trip) begin
					next_power = psfs_pkg::PSFS_ON;
				end
			end

			psfs_pkg::PSFS_ON: begin
				if (!enable) begin
					next_power = psfs_pkg::PSFS_BREAK;
					next_power_cnt = psfs_pkg::CNT_ZERO;
				end else if (sense.input_below_trip) begin
					// R1 R5 qualified undervoltage disengages load
					if (blank_done) begin
						next_power = psfs_pkg::PSFS_RETRY;
						next_power_cnt = psfs_pkg::CNT_ZERO;
					end else begin
						// R15 blanking counted in cycles
						next_power_cnt = power_cnt + psfs_pkg::CNT_ONE;
					end
				end else begin
					// R7 R4 upward crossing restarts blanking
					next_power_cnt = psfs_pkg::CNT_ZERO;
				end
			end

			psfs_pkg::PSFS_RETRY: begin
				if (!enable) begin
					next_power = psfs_pkg::PSFS_BREAK;
					next_power_cnt = psfs_pkg::CNT_ZERO;
				// R2 R3 reapply after retry wait, whatever the input
				end else if (retry_done) begin
					next_power = psfs_pkg::PSFS_ON;
					next_power_cnt = psfs_pkg::CNT_ZERO;
				end else begin
					next_power_cnt = power_cnt + psfs_pkg::CNT_ONE;
				end
			end

			psfs_pkg::PSFS_BREAK: begin
				// R14 pass already off, shunt next
				next_power_cnt = psfs_pkg::CNT_ZERO;
				next_power = psfs_pkg::PSFS_DISABLED;
			end

			default: begin
				next_power = psfs_pkg::PSFS_BREAK;
				next_power_cnt = psfs_pkg::CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			power <= psfs_pkg::PSFS_DISABLED;
			power_cnt <= psfs_pkg::CNT_ZERO;
		end else begin
			power <= next_power;
			power_cnt <= next_power_cnt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// surge allowance state

	psfs_pkg::psfs_surge_t              surge;
	psfs_pkg::psfs_surge_t              next_surge;
	logic [psfs_pkg::CNT_W-1:0]         surge_cnt;
	logic [psfs_pkg::CNT_W-1:0]         next_surge_cnt;
	logic                               conducting;
	// end-of-period flags of the shared surge and lock-out counter
	logic                               surge_done;
	logic                               lock_done;

	// the surge timer keeps running through an undervoltage retry
	assign conducting = (power == psfs_pkg::PSFS_ON);

	assign surge_done = (surge_cnt == SURGE_CYCLES - psfs_pkg::CNT_ONE);
	assign lock_done  = (surge_cnt == LOCKOUT_CYCLES - psfs_pkg::CNT_ONE);

	always_comb begin
		next_surge = surge;
		next_surge_cnt = surge_cnt;
		case (surge)
			psfs_pkg::PSFS_READY: begin
				next_surge_cnt = psfs_pkg::CNT_ZERO;
				if (sense.over_temp) begin
					// R13 no surge granted around a thermal event
					if (sense.over_primary) begin
						next_surge = psfs_pkg::PSFS_LIMIT;
					end
				// R8 surge begins on secondary limit
				end else if (conducting && sense.over_primary) begin
					next_surge = psfs_pkg::PSFS_SURGE;
				end
			end

			psfs_pkg::PSFS_SURGE: begin
				// R12 thermal ends the surge
				if (sense.over_temp) begin
					next_surge = psfs_pkg::PSFS_LIMIT;
					next_surge_cnt = psfs_pkg::CNT_ZERO;
				end else if (!sense.over_primary) begin
					// R11 surge over, lock out
					next_surge = psfs_pkg::PSFS_LOCK;
					next_surge_cnt = psfs_pkg::CNT_ZERO;
				// R8 period ends, primary takes over
				end else if (surge_done) begin
					next_surge = psfs_pkg::PSFS_LIMIT;
					next_surge_cnt = psfs_pkg::CNT_ZERO;
				end else begin
					// R15 surge period counted
					next_surge_cnt = surge_cnt + psfs_pkg::CNT_ONE;
				end
			end

			psfs_pkg::PSFS_LIMIT: begin
				next_surge_cnt = psfs_pkg::CNT_ZERO;
				// R10 R13 hold primary while overload or heat
				if (!sense.over_primary && !sense.over_temp) begin
					next_surge = psfs_pkg::PSFS_LOCK;
				end
			end

			psfs_pkg::PSFS_LOCK: begin
				// R11 a new overload only gets primary limiting
				if (sense.over_primary || sense.over_temp) begin
					next_surge = psfs_pkg::PSFS_LIMIT;
					next_surge_cnt = psfs_pkg::CNT_ZERO;
				end else if (lock_done) begin
					next_surge = psfs_pkg::PSFS_READY;
					next_surge_cnt = psfs_pkg::CNT_ZERO;
				end else begin
					// R15 lock-out counted
					next_surge_cnt = surge_cnt + psfs_pkg::CNT_ONE;
				end
			end

			default: begin
				next_surge = psfs_pkg::PSFS_LOCK;
				next_surge_cnt = psfs_pkg::CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			surge <= psfs_pkg::PSFS_READY;
			surge_cnt <= psfs_pkg::CNT_ZERO;
		end else begin
			surge <= next_surge;
			surge_cnt <= next_surge_cnt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// drive and status

	psfs_pkg::psfs_drive_t              next_drive;
	psfs_pkg::psfs_status_t             next_status;

	always_comb begin
		// everything off unless the state below turns it on
		next_drive = '0;
		case (next_power)
			psfs_pkg::PSFS_DISABLED: begin
				// R14 shunt only once the pass is off
				next_drive.shunt_on = 1'b1;
			end

			psfs_pkg::PSFS_ON: begin
				// R12 R5 pass follows power state, gated by heat
				next_drive.pass_on = !sense.over_temp;
			end

			default: begin
				// R16 arm, retry and break hold both switches off
				next_drive.shunt_on = 1'b0;
			end
		endcase
		// the secondary limit only matters while conducting
		next_drive.secondary_limit_sel =
			(next_surge == psfs_pkg::PSFS_SURGE) && next_drive.pass_on;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			drive <= psfs_pkg::DRIVE_RESET;
		end else begin
			drive <= next_drive;
		end
	end

	always_comb begin
		next_status = psfs_pkg::STATUS_RESET;
		next_status.uv_disengaged = (next_power == psfs_pkg::PSFS_RETRY);
		case (next_surge)
			psfs_pkg::PSFS_SURGE: begin
				next_status.surge_active = 1'b1;
			end

			psfs_pkg::PSFS_LIMIT: begin
				next_status.primary_limiting = 1'b1;
			end

			psfs_pkg::PSFS_LOCK: begin
				next_status.lockout_active = 1'b1;
			end

			default: begin
				// ready shows no surge activity at all
				next_status.surge_active = 1'b0;
			end
		endcase
		// thermal flag trails the comparator by one clock
		next_status.thermal_off = sense.over_temp;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			status <= psfs_pkg::STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// combinational so a hard short is clamped without waiting a clock
	// R9 clamp bypasses every timer
	assign secondary_clamp = sense.secondary_overcurrent && drive.pass_on;

endmodule

// ### psfs_far_end.sv
// far-side stand-in: comparators and current sensors of the power stage
// assumes the bench sets the analogue conditions at the falling edge
module psfs_far_end (
	input  wire logic                  below,
	input  wire logic                  heavy,
	input  wire logic                  shorted,
	input  wire logic                  hot,
	input  wire psfs_pkg::psfs_drive_t drive,
	output psfs_pkg::psfs_sense_t      sense
);
	// no load current can flow while the pass switch is off
	assign sense = '{below, heavy & drive.pass_on,
		shorted & drive.pass_on, hot};
endmodule

// ### psfs_sequencer_asserts.sv
// checker for the power switch fault sequencer
// sees top ports only; repeat counts suit the bench's short periods
module psfs_sequencer_asserts #(
	parameter logic [psfs_pkg::CNT_W-1:0] RETRY_CYCLES = 26'h0000008
) (
	input wire logic                   clock,
	input wire logic                   nrst,
	input wire logic                   enable,
	input wire psfs_pkg::psfs_sense_t  sense,
	input wire psfs_pkg::psfs_drive_t  drive,
	input wire logic                   secondary_clamp,
	input wire psfs_pkg::psfs_status_t status
);
	localparam int RETRY_M1 = int'(RETRY_CYCLES) - 1;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence blank_run;
		(sense.input_below_trip && drive.pass_on && enable
			&& !sense.over_temp)[*6];
	endsequence
	sequence uv_start;
		$rose(status.uv_disengaged);
	endsequence
	sequence surge_start;
		$rose(drive.secondary_limit_sel);
	endsequence
	//////////////////////////////////////////////////////////////////////
	AST_BLANK: assert property (blank_run |=> !drive.pass_on)
		else $error("load not dropped after blanking");
	AST_BLANK_FULL: assert property (uv_start |->
		$past(sense.input_below_trip, 6)) else $error("short blanking");
	AST_RETRY: assert property (uv_start |-> !drive.pass_on
		##RETRY_M1 !drive.pass_on ##1 drive.pass_on)
		else $error("retry wait length wrong");
	AST_SURGE_GO: assert property (!status.surge_active
		&& !status.primary_limiting && !status.lockout_active
		&& drive.pass_on && enable && sense.over_primary
		&& !sense.over_temp && !sense.input_below_trip
		|=> drive.secondary_limit_sel) else $error("surge not granted");
	AST_SURGE_END: assert property (surge_start ##0
		(sense.over_primary && !sense.over_temp)[*4]
		|-> drive.secondary_limit_sel ##2 !drive.secondary_limit_sel)
		else $error("surge period length wrong");
	AST_CLAMP: assert property (secondary_clamp ==
		(sense.secondary_overcurrent && drive.pass_on))
		else $error("clamp not immediate");
	AST_HOLD: assert property (status.primary_limiting
		&& sense.over_primary |=> status.primary_limiting)
		else $error("limiting left under overload");
	AST_LOCK: assert property (status.lockout_active
		|=> !drive.secondary_limit_sel) else $error("surge in lock-out");
	AST_HOT: assert property (sense.over_temp |=> !drive.pass_on
		&& !drive.secondary_limit_sel) else $error("hot but conducting");
	AST_BREAK: assert property (drive.pass_on && !enable
		|=> !drive.pass_on ##1 drive.shunt_on)
		else $error("disable order wrong");
	AST_MAKE: assert property ($rose(drive.pass_on)
		|-> !$past(drive.shunt_on)) else $error("shunt on at turn-on");
	AST_EXCL: assert property (!(drive.pass_on
		&& drive.shunt_on)) else $error("pass and shunt both on");
endmodule
bind psfs_sequencer psfs_sequencer_asserts #(
	.RETRY_CYCLES(RETRY_CYCLES)
) i_asserts (.clock(clock), .nrst(nrst), .enable(enable), .sense(sense),
	.drive(drive), .secondary_clamp(secondary_clamp), .status(status));

// ### tb_power_switch_fault_sequencer.sv
// self-checking bench for the power switch fault sequencer
// assumes shortened periods; the far side is a behavioural stand-in
module tb_power_switch_fault_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BLANK = 6;
	localparam int RETRY = 8;
	localparam int SURGE = 5;
	localparam int LOCK  = 7;
	logic                   clock = 1'b0;
	logic                   nrst = 1'b0;
	logic                   enable = 1'b0;
	logic                   below = 1'b0;
	logic                   heavy = 1'b0;
	logic                   shorted = 1'b0;
	logic                   hot = 1'b0;
	psfs_pkg::psfs_sense_t  sense;
	psfs_pkg::psfs_drive_t  drive;
	psfs_pkg::psfs_status_t status;
	logic                   clamp;
	int                     error_cnt = 0;
	int                     n_checks = 0;
	int                     k;
	psfs_sequencer #(.BLANK_CYCLES(26'h0000006), .RETRY_CYCLES(26'h0000008),
		.SURGE_CYCLES(26'h0000005), .LOCKOUT_CYCLES(26'h0000007)) i_dut (
		.clock(clock), .nrst(nrst), .enable(enable), .sense(sense),
		.drive(drive), .secondary_clamp(clamp), .status(status));
	psfs_far_end i_far (.below(below), .heavy(heavy), .shorted(shorted),
		.hot(hot), .drive(drive), .sense(sense));
	initial forever #2 clock = ~clock;
	//////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#4000;
		error_cnt++;
		complete_run();
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		k = $urandom(32'h4507417c);
		cyc(6);
		nrst = 1'b1;
		chk("reset", 8'h20, {drive, status});
		enable = 1'b1;
		cyc(1);
		chk("arm", 8'h00, {drive, status});
		cyc(1);
		chk("on", 8'h80, {drive, status});
		$display("test enable done");
		below = 1'b1;
		k = $urandom_range(BLANK - 1, 1);
		cyc(k);
		below = 1'b0;
		cyc(1);
		below = 1'b1;
		cyc(BLANK - 1);
		chk("glitch", 8'h80, {drive, status});
		cyc(1);
		chk("uv off", 8'h10, {drive, status});
		cyc(RETRY - 1);
		chk("retry wait", 8'h10, {drive, status});
		cyc(1);
		chk("reapply", 8'h80, {drive, status});
		cyc(BLANK - 1);
		chk("powered", 8'h80, {drive, status});
		cyc(1);
		chk("again off", 8'h10, {drive, status});
		below = 1'b0;
		cyc(RETRY + BLANK + 2);
		chk("resume", 8'h80, {drive, status});
		$display("test undervoltage done");
		heavy = 1'b1;
		cyc(1);
		chk("surge", 8'hc8, {drive, status});
		shorted = 1'b1;
		#1 chk("clamp", 8'h01, {7'h00, clamp});
		cyc(SURGE - 1);
		shorted = 1'b0;
		chk("surge held", 8'hc8, {drive, status});
		cyc(1);
		chk("limit", 8'h84, {drive, status});
		cyc(3);
		chk("limit held", 8'h84, {drive, status});
		heavy = 1'b0;
		cyc(1);
		chk("lockout", 8'h82, {drive, status});
		heavy = 1'b1;
		cyc(2);
		chk("no surge", 8'h84, {drive, status});
		heavy = 1'b0;
		cyc(LOCK);
		chk("lock end", 8'h82, {drive, status});
		cyc(1);
		chk("ready", 8'h80, {drive, status});
		$display("test surge done");
		heavy = 1'b1;
		cyc(1);
		chk("surge2", 8'hc8, {drive, status});
		hot = 1'b1;
		cyc(1);
		chk("hot", 8'h05, {drive, status});
		hot = 1'b0;
		cyc(1);
		chk("cool", 8'h80, {drive, 5'h00} & 8'hc0);
		cyc(2);
		chk("cool held", 8'h80, {drive, 5'h00} & 8'hc0);
		$display("test thermal done");
		heavy = 1'b0;
		enable = 1'b0;
		cyc(1);
		chk("break", 8'h00, {drive, 5'h00});
		cyc(1);
		chk("shunt", 8'h20, {drive, 5'h00});
		below = 1'b1;
		enable = 1'b1;
		cyc(3);
		chk("wait trip", 8'h00, {drive, 5'h00});
		below = 1'b0;
		cyc(1);
		chk("make", 8'h80, {drive, 5'h00});
		$display("test discharge done");
		complete_run();
	end
endmodule
